// ==== verilog/samdu_pkg.sv ====
package samdu_pkg;
    // ------------------------------------------------------------
    // word timing
    // ------------------------------------------------------------
    localparam int unsigned WORD_BITS = 24;
    localparam logic [4:0] P_FIRST = 5'h01;
    localparam logic [4:0] P_SECOND = 5'h02;
    localparam logic [4:0] P_SIGN = 5'h17;
    localparam logic [4:0] P_LAST = 5'h18;

    // ------------------------------------------------------------
    // opcodes (octal 14..17, 31, 32, 75)
    // ------------------------------------------------------------
    localparam logic [5:0] OP_ADD = 6'h0c;
    localparam logic [5:0] OP_SUB = 6'h0d;
    localparam logic [5:0] OP_DADD = 6'h0e;
    localparam logic [5:0] OP_DSUB = 6'h0f;
    localparam logic [5:0] OP_DIV = 6'h19;
    localparam logic [5:0] OP_MUL = 6'h1a;
    localparam logic [5:0] OP_OVF_TEST = 6'h3d;
    localparam int unsigned OPCODE_BIT_TWO = 1;

    // ------------------------------------------------------------
    // register port map and status field positions
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_A = 4'h0;
    localparam logic [3:0] ADDR_B = 4'h4;
    localparam logic [3:0] ADDR_C = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_OVERFLOW = 1;
    localparam int unsigned ST_PARITY = 2;
    localparam int unsigned ST_CARRY = 3;
    localparam logic [23:0] WORD_RESET = 24'h000000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [5:0] opcode;
        logic [4:0] sectors;
    } samdu_cmd_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } samdu_bus_t;
endpackage

// ==== verilog/samdu_serial_adder.sv ====
`timescale 1ns/1ps
module samdu_serial_adder (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic en_i,
    input wire logic x_i,
    input wire logic y_i,
    input wire logic carry_set_i,
    input wire logic carry_clr_i,
    output logic sum_o,
    output logic carry_o
);
    logic carry_q;
    logic carry_in;

    // a set this cycle already feeds the current bit
    assign carry_in = carry_set_i | carry_q;
    assign sum_o = x_i ^ y_i ^ carry_in;
    assign carry_o = carry_q;

    // carry: clear wins at word end, else generate/kill/propagate
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            carry_q <= 1'b0;
        end else if (carry_clr_i) begin
            carry_q <= 1'b0;
        end else if (en_i) begin
            if (x_i && y_i) begin
                carry_q <= 1'b1;
            end else if (!x_i && !y_i) begin
                carry_q <= 1'b0;
            end else begin
                carry_q <= carry_in;
            end
        end else if (carry_set_i) begin
            carry_q <= 1'b1;
        end
    end
endmodule // samdu_serial_adder

// ==== verilog/samdu_unit.sv ====
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - opcodes 14-17 add or subtract memory into A, or B then A when double
// - memory bit enters true for 14 and 16, inverted for 15 and 17
// - register operand is B for 16 and 17, A for 14 and 15
// - double forms clear opcode bit two after the first sector
// - carry cleared before execution, set at its start for 15 and 17
// - overflow set at sign time when like-signed inputs give unlike sum
// - overflow-test opcode 75 clears the overflow flag
// - add opcodes check memory parity; odd parity sets error and halts
// - opcode 32 multiplies C by B, AB shifting right each sector
// - first-sector flag false in first sector, set at its pulse 24
// - bit pair 00 or 11 adds zero, 01 adds C, 10 subtracts C
// - add-code flag set at P1 on early 0 current 1, cleared at P24
// - subtract-code flag set at P1 on early 1 current 0, sets carry
// - first multiply sector gates register operand off, clearing A
// - lowest position of B is held clear in all recirculation
// - B shifts right; A end bit caught at P2, put into B at P23
// - first sector repeats B sign into P23; C sign extends into P24
// - last sector sign pair adds zero, leaving half product in AB
// - opcode 31 divides AB by C, shifting left, quotient bits into B
// - subtract flag set when A and C signs match, at read and each sector
// - divide with subtract flag sets carry at P1, clears it at P24
// - divide sum delayed one bit into A; B left end bit enters A right
module samdu_unit (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire samdu_pkg::samdu_cmd_t cmd_i,
    input wire logic mem_bit_i,
    input wire samdu_pkg::samdu_bus_t bus_i,
    output logic [31:0] rdata_o,
    output logic cmd_ready_o,
    output logic busy_o,
    output logic halt_o,
    output logic overflow_o,
    output logic [4:0] pulse_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] samdu_rot(input logic [23:0] v, input logic [4:0] n);
        logic [47:0] w;
        w = {v, v} >> n;
        return w[23:0];
    endfunction

    function automatic logic is_add_op(input logic [5:0] op);
        return op[5:2] == samdu_pkg::OP_ADD[5:2];
    endfunction

    typedef enum logic [1:0] {
        SAMDU_IDLE = 2'b00,
        SAMDU_READ = 2'b01,
        SAMDU_EXEC = 2'b10
    } samdu_state_t;

    samdu_state_t state_q;
    logic [4:0] pulse_q;
    logic [23:0] a_q, b_q, c_q;
    logic [5:0] op_q;
    logic [4:0] sect_q;
    logic overflow_flag, parity_error_flag, first_sector_flag;
    logic add_code_flag, subtract_code_flag, shift_link_bit, sum_delay_bit;
    logic b_delay_q, par_q;
    logic adder_operand_one, adder_operand_two, adder_sum_bit, adder_carry_flag;
    logic carry_set, carry_clr, adder_en;
    logic a_in, b_in, c_in;
    logic p1, p2, p23, p24, exec, accept, is_add, is_mul, is_div, last_sect, quot;
    logic a_current_bit, a_early_bit, b_current_bit, b_early_bit, c_current_bit;
    logic [4:0] rot_wr, rot_rd;
    logic [23:0] rd_word;

    assign p1 = pulse_q == samdu_pkg::P_FIRST;
    assign p2 = pulse_q == samdu_pkg::P_SECOND;
    assign p23 = pulse_q == samdu_pkg::P_SIGN;
    assign p24 = pulse_q == samdu_pkg::P_LAST;
    assign a_current_bit = a_q[0];
    assign a_early_bit = a_q[1];
    assign b_current_bit = b_q[0];
    assign b_early_bit = b_q[1];
    assign c_current_bit = c_q[0];
    assign exec = state_q == SAMDU_EXEC;
    assign is_add = exec && is_add_op(op_q);
    assign is_mul = exec && op_q == samdu_pkg::OP_MUL;
    assign is_div = exec && op_q == samdu_pkg::OP_DIV;
    assign last_sect = sect_q == 5'h01;
    assign cmd_ready_o = state_q == SAMDU_IDLE && p23 && !parity_error_flag;
    assign accept = cmd_ready_o && cmd_i.valid;
    assign busy_o = state_q != SAMDU_IDLE;
    assign halt_o = parity_error_flag;
    assign overflow_o = overflow_flag;
    assign pulse_o = pulse_q;

    // ------------------------------------------------------------
    // pulse time counter, 1..24
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pulse_q <= samdu_pkg::P_FIRST;
        end else if (p24) begin
            pulse_q <= samdu_pkg::P_FIRST;
        end else begin
            pulse_q <= pulse_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // command phases: read ends at P24, execution by sectors
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= SAMDU_IDLE;
            op_q <= 6'h00;
            sect_q <= 5'h00;
        end else if (accept) begin
            state_q <= SAMDU_READ;
            op_q <= cmd_i.opcode;
            if (is_add_op(cmd_i.opcode)) begin
                sect_q <= cmd_i.opcode[samdu_pkg::OPCODE_BIT_TWO] ? 5'h02 : 5'h01;
            end else if (cmd_i.opcode == samdu_pkg::OP_MUL || cmd_i.opcode == samdu_pkg::OP_DIV) begin
                sect_q <= (cmd_i.sectors == 5'h00) ? 5'h01 : cmd_i.sectors;
            end else begin
                sect_q <= 5'h01;
            end
        end else if (p24) begin
            unique case (state_q)
                SAMDU_READ: state_q <= SAMDU_EXEC;
                SAMDU_EXEC: begin
                    if (last_sect || (is_add && (par_q ^ mem_bit_i))) begin
                        state_q <= SAMDU_IDLE;
                    end
                    sect_q <= sect_q - 5'h01;
                    op_q[samdu_pkg::OPCODE_BIT_TWO] <= op_q[samdu_pkg::OPCODE_BIT_TWO]
                        & ~is_add;
                end
                default: state_q <= SAMDU_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // adder operands
    // ------------------------------------------------------------
    always_comb begin
        adder_operand_one = 1'b0;
        adder_operand_two = 1'b0;
        if (is_add) begin
            adder_operand_one = mem_bit_i ^ op_q[0];
            adder_operand_two = op_q[1] ? b_current_bit : a_current_bit;
        end else if (is_mul) begin
            if (p1) begin
                adder_operand_one = (!b_early_bit && b_current_bit && c_current_bit)
                    || (b_early_bit && !b_current_bit && !c_current_bit);
            end else begin
                adder_operand_one = (add_code_flag && c_current_bit)
                    || (subtract_code_flag && !c_current_bit);
            end
            if (first_sector_flag) begin
                adder_operand_two = p24 ? a_current_bit : a_early_bit;
            end
        end else if (is_div) begin
            adder_operand_one = subtract_code_flag ^ c_current_bit;
            adder_operand_two = a_current_bit;
        end
    end

    // carry control
    assign carry_set = (state_q == SAMDU_READ && p24 && is_add_op(op_q) && op_q[0])
        || (is_mul && p1 && b_early_bit && !b_current_bit)
        || (is_div && p1 && subtract_code_flag);
    assign carry_clr = accept || ((is_mul || is_div) && p24);
    assign adder_en = is_mul || is_div || (is_add && !p24);

    samdu_serial_adder u_adder (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .en_i(adder_en),
        .x_i(adder_operand_one),
        .y_i(adder_operand_two),
        .carry_set_i(carry_set),
        .carry_clr_i(carry_clr),
        .sum_o(adder_sum_bit),
        .carry_o(adder_carry_flag)
    );

    // ------------------------------------------------------------
    // overflow and parity flags; hardware set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            overflow_flag <= 1'b0;
        end else if (is_add && !op_q[1] && p23
                     && adder_operand_one == adder_operand_two
                     && adder_sum_bit != adder_operand_one) begin
            overflow_flag <= 1'b1;
        end else if (exec && op_q == samdu_pkg::OP_OVF_TEST && p23) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            par_q <= 1'b0;
            parity_error_flag <= 1'b0;
        end else begin
            par_q <= (is_add && !p24) ? (par_q ^ mem_bit_i) : 1'b0;
            if (is_add && p24 && (par_q ^ mem_bit_i)) begin
                parity_error_flag <= 1'b1;
            end else if (bus_i.wr && bus_i.addr == samdu_pkg::ADDR_STATUS
                         && bus_i.wdata[samdu_pkg::ST_PARITY]) begin
                parity_error_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencing flip-flops for multiply and divide
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            first_sector_flag <= 1'b0;
            add_code_flag <= 1'b0;
            subtract_code_flag <= 1'b0;
        end else begin
            if (accept) begin
                first_sector_flag <= 1'b0;
            end else if ((is_mul || is_div) && p24) begin
                first_sector_flag <= 1'b1;
            end
            if (is_mul && p24) begin
                add_code_flag <= 1'b0;
            end else if (is_mul && p1 && !b_early_bit && b_current_bit) begin
                add_code_flag <= 1'b1;
            end
            if (accept) begin
                subtract_code_flag <= cmd_i.opcode == samdu_pkg::OP_DIV
                    && a_current_bit == c_current_bit;
            end else if (is_div && p24) begin
                subtract_code_flag <= sum_delay_bit == c_current_bit;
            end else if (is_mul && p24) begin
                subtract_code_flag <= 1'b0;
            end else if (is_mul && p1 && b_early_bit && !b_current_bit) begin
                subtract_code_flag <= 1'b1;
            end
        end
    end

    // link, delay and sign-history bits
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            shift_link_bit <= 1'b0;
            sum_delay_bit <= 1'b0;
            b_delay_q <= 1'b0;
        end else begin
            b_delay_q <= b_current_bit;
            sum_delay_bit <= adder_sum_bit;
            if (is_mul && !first_sector_flag) begin
                shift_link_bit <= b_early_bit;
            end else if (is_mul && p2) begin
                shift_link_bit <= a_current_bit;
            end else if (is_div && p24) begin
                shift_link_bit <= b_delay_q;
            end
        end
    end

    // ------------------------------------------------------------
    // register input bits
    // ------------------------------------------------------------
    assign quot = first_sector_flag ? subtract_code_flag : !subtract_code_flag;

    always_comb begin
        a_in = a_current_bit;
        b_in = b_current_bit;
        if (is_add && !p24) begin
            if (op_q[1]) begin
                b_in = adder_sum_bit;
            end else begin
                a_in = adder_sum_bit;
            end
        end else if (is_mul) begin
            a_in = adder_sum_bit;
            if (p23) begin
                b_in = shift_link_bit;
            end else if (!p24) begin
                b_in = b_early_bit;
            end
        end else if (is_div) begin
            a_in = p2 ? shift_link_bit : sum_delay_bit;
            if (p2) begin
                b_in = quot;
            end else if (!p24) begin
                b_in = b_delay_q;
            end
        end
        if (p1) begin
            a_in = is_div ? 1'b0 : a_in;
            b_in = 1'b0;
        end
    end

    // sign slot is read from the register itself, so a port write never leaves it stale
    assign c_in = p24 ? c_q[23] : c_current_bit;

    // ------------------------------------------------------------
    // recirculating registers and register port
    // ------------------------------------------------------------
    assign rot_wr = p24 ? 5'h00 : pulse_q;
    assign rot_rd = p1 ? 5'h00 : 5'h19 - pulse_q;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            a_q <= samdu_pkg::WORD_RESET;
            b_q <= samdu_pkg::WORD_RESET;
            c_q <= samdu_pkg::WORD_RESET;
        end else begin
            a_q <= {a_in, a_q[23:1]};
            b_q <= {b_in, b_q[23:1]};
            c_q <= {c_in, c_q[23:1]};
            if (bus_i.wr && !busy_o) begin
                unique case (bus_i.addr)
                    samdu_pkg::ADDR_A: a_q <= samdu_rot(bus_i.wdata[23:0], rot_wr);
                    samdu_pkg::ADDR_B: b_q <= samdu_rot({bus_i.wdata[23:1], 1'b0}, rot_wr);
                    samdu_pkg::ADDR_C: c_q <= samdu_rot({bus_i.wdata[22], bus_i.wdata[22:0]},
                        rot_wr);
                    default: ;
                endcase
            end
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_comb begin
        unique case (bus_i.addr)
            samdu_pkg::ADDR_A: rd_word = samdu_rot(a_q, rot_rd);
            samdu_pkg::ADDR_B: rd_word = samdu_rot(b_q, rot_rd);
            samdu_pkg::ADDR_C: rd_word = samdu_rot(c_q, rot_rd);
            samdu_pkg::ADDR_STATUS: rd_word = {20'h00000, adder_carry_flag,
                parity_error_flag, overflow_flag, busy_o};
            default: rd_word = 24'h000000;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 32'h00000000;
        end else if (bus_i.rd) begin
            rdata_o <= {8'h00, rd_word};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    AST_DP_CLEARS_BIT: assert property (is_add && op_q[1] && p24 && !last_sect
        |=> !op_q[1]) else $error("double add kept opcode bit two");
    AST_SUB_CARRY: assert property (state_q == SAMDU_READ && p24 && op_q[0]
        && is_add_op(op_q) |=> adder_carry_flag) else $error("sub carry not set");
    AST_OVF_CLEAR: assert property (exec && op_q == samdu_pkg::OP_OVF_TEST && p23
        |=> !overflow_o) else $error("overflow not cleared");
    AST_PARITY_HALT: assert property (is_add && p24 && (par_q ^ mem_bit_i)
        |=> halt_o && !busy_o) else $error("odd parity did not halt");
    AST_FIRST_SECTOR: assert property ($rose(exec) && (is_mul || is_div)
        |-> !first_sector_flag [*8]) else $error("first sector flag early");
    AST_ADD_CODE_CLR: assert property (is_mul && p24
        |=> !add_code_flag && !subtract_code_flag) else $error("code flags stuck");
    AST_B_LOW_CLEAR: assert property (p1 |=> !b_q[23])
        else $error("B lowest position not clear");
    AST_C_SIGN_EXT: assert property (p24 |=> c_q[23] == c_q[22])
        else $error("C sign not extended");
    AST_DIV_CARRY: assert property (is_div && p1 && subtract_code_flag
        |-> adder_sum_bit == (adder_operand_one ^ adder_operand_two ^ 1'b1))
        else $error("divide carry missing");
    AST_OVF_SET: assert property (is_add && !op_q[1] && p23 && adder_operand_one
        && adder_operand_two && !adder_sum_bit |=> overflow_o) else $error("overflow missed");
endmodule // samdu_unit

// ==== dv/samdu_mem_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// delay-line memory and command phase control
// ------------------------------------------------------------
module samdu_mem_model (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic [5:0] opcode_i,
    input wire logic [4:0] sectors_i,
    input wire logic [22:0] word0_i,
    input wire logic [22:0] word1_i,
    input wire logic bad_parity_i,
    input wire logic [4:0] pulse_i,
    input wire logic cmd_ready_i,
    input wire logic busy_i,
    output samdu_pkg::samdu_cmd_t cmd_o,
    output logic mem_bit_o
);
    logic req_q;
    logic first_q;
    logic idx_q;
    logic taken;
    logic [22:0] word;
    assign taken = req_q && pulse_i == samdu_pkg::P_SIGN && cmd_ready_i;
    assign word = idx_q ? word1_i : word0_i;
    assign cmd_o = '{valid: req_q, opcode: opcode_i, sectors: sectors_i};
    // request held until the datapath takes it at sign time
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            req_q <= 1'b0;
        end else if (start_i) begin
            req_q <= 1'b1;
        end else if (taken) begin
            req_q <= 1'b0;
        end
    end
    // picks the stored word for each execution sector; read phase skipped
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            first_q <= 1'b0;
            idx_q <= 1'b0;
        end else if (taken) begin
            first_q <= 1'b1;
            idx_q <= 1'b0;
        end else if (pulse_i == samdu_pkg::P_LAST) begin
            first_q <= 1'b0;
            idx_q <= idx_q ^ !first_q;
        end
    end
    // word bits in pulse order, even parity last; idle line toggles
    always_comb begin
        if (!busy_i) begin
            mem_bit_o = pulse_i[0];
        end else if (pulse_i == samdu_pkg::P_LAST) begin
            mem_bit_o = (^word) ^ bad_parity_i;
        end else begin
            mem_bit_o = word[pulse_i-5'h01];
        end
    end
endmodule // samdu_mem_model

// ==== dv/tb_samdu_unit.sv ====
`timescale 1ns/1ps
module tb_samdu_unit;
    typedef struct packed {logic [3:0] addr; logic [31:0] exp; logic [31:0] mask;} samdu_note_t;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    samdu_pkg::samdu_bus_t bus = '0;
    samdu_pkg::samdu_cmd_t cmd;
    logic mem_bit, cmd_ready, busy, halt, overflow, rd_seen = 1'b0;
    logic [31:0] rdata;
    logic [4:0] pulse;
    logic start = 1'b0, bad = 1'b0, ov_exp = 1'b0;
    logic [5:0] op = 6'h0c;
    logic [4:0] nsec = 5'h01;
    logic [22:0] w0 = '0, w1 = '0;
    int failures = 0, checks = 0, seed = 44954;
    samdu_note_t note_q[$];
    samdu_note_t note;
    always #2 clk_sys_i = ~clk_sys_i;
    samdu_unit i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_i(cmd), .mem_bit_i(mem_bit),
        .bus_i(bus), .rdata_o(rdata), .cmd_ready_o(cmd_ready), .busy_o(busy), .halt_o(halt),
        .overflow_o(overflow), .pulse_o(pulse));
    samdu_mem_model i_mem (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .start_i(start),
        .opcode_i(op), .sectors_i(nsec), .word0_i(w0), .word1_i(w1), .bad_parity_i(bad),
        .pulse_i(pulse), .cmd_ready_i(cmd_ready), .busy_i(busy), .cmd_o(cmd), .mem_bit_o(mem_bit));
    // ------------------------------------------------------------
    // bus and command tasks
    // ------------------------------------------------------------
    task automatic bus_wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: {8'h00, d}, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        note_q.push_back('{a, e & m, m});
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
    endtask
    task automatic run_cmd(input logic [5:0] o, input logic [4:0] n, input logic [22:0] m0,
            input logic [22:0] m1, input logic e);
        int k;
        @(posedge clk_sys_i);
        op <= o;
        nsec <= n;
        w0 <= m0;
        w1 <= m1;
        bad <= e;
        start <= 1'b1;
        @(posedge clk_sys_i);
        start <= 1'b0;
        for (k = 0; k < 60 && busy !== 1'b1; k++) @(posedge clk_sys_i);
        check_pin("busy_o rise", 1'b1, busy);
        for (k = 0; k < 900 && busy !== 1'b0; k++) @(posedge clk_sys_i);
        check_pin("busy_o fall", 1'b0, busy);
        $display("test opcode %h done", o);
    endtask
    task automatic check_word(input samdu_note_t n, input logic [31:0] seen);
        checks++;
        if ((seen & n.mask) !== n.exp) begin
            failures++;
            $display("CHECK FAILED register %h expected %h seen %h", n.addr, n.exp, seen & n.mask);
        end
    endtask
    task automatic check_pin(input string name, input logic e, input logic s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, e, s);
        end
    endtask
    // single or double add/subtract with expectations from two's complement sums
    task automatic add_case(input logic [5:0] o, input logic [22:0] a, input logic [22:0] b,
            input logic [22:0] m0, input logic [22:0] m1);
        logic [23:0] s;
        logic [22:0] x;
        bus_wr(samdu_pkg::ADDR_A, {1'b0, a});
        bus_wr(samdu_pkg::ADDR_B, {1'b0, b});
        run_cmd(o, 5'h01, m0, m1, 1'b0);
        x = o[0] ? ~m0 : m0;
        s = {23'h0, o[0]};
        if (o[1]) begin
            s = {1'b0, b[22:1], 1'b0} + {1'b0, x} + s;
            bus_rd(samdu_pkg::ADDR_B, {9'h0, s[22:1], 1'b0}, 32'hff7fffff);
            x = o[0] ? ~m1 : m1;
            s = {23'h0, s[23]};
        end
        s = {1'b0, a} + {1'b0, x} + s;
        ov_exp = ov_exp | (a[22] == x[22] && s[22] != a[22]);
        bus_rd(samdu_pkg::ADDR_A, {9'h0, s[22:0]}, 32'hff7fffff);
        bus_rd(samdu_pkg::ADDR_STATUS, {30'h0, ov_exp, 1'b0}, 32'h7);
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // compares each read answer with the oldest noted expectation
    always @(posedge clk_sys_i) begin
        if (rd_seen) begin
            note = note_q.pop_front();
            check_word(note, rdata);
            if (note.addr == samdu_pkg::ADDR_STATUS && note.mask[1]) begin
                check_pin("overflow_o", note.exp[1], overflow);
            end
            if (note.addr == samdu_pkg::ADDR_STATUS && note.mask[2]) begin
                check_pin("halt_o", note.exp[2], halt);
            end
        end
        rd_seen <= bus.rd;
    end
    // cuts a hang short
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        failures++;
        print_verdict;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 16; i += 2) bus_rd(i[3:0], 32'h0, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            add_case(samdu_pkg::OP_ADD + 6'(i % 4), 23'($random(seed)), 23'($random(seed)),
                23'($random(seed)), 23'($random(seed)));
        end
        add_case(samdu_pkg::OP_ADD, 23'h3fffff, 23'h0, 23'h000001, 23'h0);
        run_cmd(samdu_pkg::OP_OVF_TEST, 5'h01, 23'h0, 23'h0, 1'b0);
        ov_exp = 1'b0;
        bus_rd(samdu_pkg::ADDR_STATUS, 32'h0, 32'h7);
        run_cmd(samdu_pkg::OP_ADD, 5'h01, 23'($random(seed)), 23'h0, 1'b1);
        bus_rd(samdu_pkg::ADDR_STATUS, 32'h4, 32'h5);
        bus_wr(samdu_pkg::ADDR_STATUS, 24'h000004);
        bus_rd(samdu_pkg::ADDR_STATUS, 32'h0, 32'h4);
        bus_wr(samdu_pkg::ADDR_A, 24'($random(seed)));
        bus_wr(samdu_pkg::ADDR_B, 24'h0);
        bus_wr(samdu_pkg::ADDR_C, 24'($random(seed)));
        run_cmd(samdu_pkg::OP_MUL, 5'h06, 23'h0, 23'h0, 1'b0);
        bus_rd(samdu_pkg::ADDR_A, 32'h0, 32'hff7fffff);
        bus_rd(samdu_pkg::ADDR_B, 32'h0, 32'hff7fffff);
        for (int i = 0; i < 4; i++) begin
            bus_wr(samdu_pkg::ADDR_A, 24'($random(seed)));
            bus_wr(samdu_pkg::ADDR_B, 24'($random(seed)));
            bus_wr(samdu_pkg::ADDR_C, 24'($random(seed)));
            run_cmd(i[0] ? samdu_pkg::OP_DIV : samdu_pkg::OP_MUL, 5'(1 + i * 2), 23'h0, 23'h0, 1'b0);
            bus_rd(samdu_pkg::ADDR_B, 32'h0, i[0] ? 32'hff000000 : 32'hff000001);
            bus_rd(samdu_pkg::ADDR_STATUS, 32'h0, 32'h5);
        end
        repeat (4) @(posedge clk_sys_i);
        print_verdict;
    end
endmodule // tb_samdu_unit
